// *** hw/pmc_pkg.sv ***
package pmc_pkg;
	// operating modes of the controller
	typedef enum logic [2:0]
	{
		PMC_FULL_ON,
		PMC_ACTIVE,
		PMC_SLEEP,
		PMC_DEEP_SLEEP,
		PMC_HIBERNATE
	} pmc_mode_t;

	// software mode request codes
	localparam logic [1:0] REQ_NONE       = 2'h0;
	localparam logic [1:0] REQ_FULL_ON    = 2'h1;
	localparam logic [1:0] REQ_SLEEP      = 2'h2;
	localparam logic [1:0] REQ_DEEP_SLEEP = 2'h3;

	// field layout of pll_control_reg image
	localparam int PLL_CONTROL_REG_W       = 16;
	localparam int PLL_CONTROL_REG_OFF_BIT = 1;
	localparam int PLL_CONTROL_REG_BYP_BIT = 8;
	localparam int PLL_CONTROL_REG_MSEL_LO = 9;
	localparam int PLL_CONTROL_REG_MSEL_W  = 6;
	localparam logic [15:0] PLL_CONTROL_REG_RESET = 16'h0a00;

	// peripheral gate count default: eight gates
	localparam int PERIPH_N = 8;

	// supply codes: zero volts enters hibernate from full-on or active
	localparam logic [1:0] VCORE_OFF = 2'h0;
endpackage

// *** hw/pmc_clk_gate.sv ***
`timescale 1ns/10ps
// glitch-free clock gate: enable sampled on clock falling edge
module pmc_clk_gate
(
	input  wire logic clk_in,
	input  wire logic enable,
	input  wire logic reset,
	output logic      clk_out
);
	logic en_latch_r;

	// enable changes on falling edge only, so no runt pulse
	always_ff @(negedge clk_in or posedge reset)
	begin
		if (reset)
			en_latch_r <= 1'b0;
		else
			en_latch_r <= enable;
	end

	assign clk_out = clk_in & en_latch_r;
endmodule

// *** hw/pmc_controller.sv ***
`timescale 1ns/10ps
// Functional notes
// - five modes; full-on runs pll unbypassed, core and system clocks on
// - after reset the controller is in full-on mode
// - active mode: pll enabled but bypassed, clocks at reference rate
// - multiplier written in active applies only on next full-on entry
// - dma to level-one memory remains available in active mode
// - pll may be switched off by register write in active mode
// - sleep stops core clock; pll and system clock keep running
// - sleep wakeup samples bypass bit: clear to full-on, set to active
// - dma to level-one memory not serviced in sleep
// - zero-volt core supply write in full-on or active enters hibernate, everything off
// - each peripheral has its own clock gate
// - deep sleep stops core and system clocks, pll off, power on
// - deep sleep exits by reset to full-on or rtc to active
// - any hibernate wake starts the full hardware reset sequence
module pmc_controller
	import pmc_pkg::*;
#(
	parameter int N_PERIPH = pmc_pkg::PERIPH_N
)
(
	input  wire logic                            clk,
	input  wire logic                            reset,
	input  wire logic                            clk_en,
	input  wire logic                            pll_clk,
	input  wire logic                            input_ref_clock,
	input  wire logic                            ctl_wr,
	input  wire logic [pmc_pkg::PLL_CONTROL_REG_W-1:0]   ctl_wdata,
	input  wire logic [1:0]                      mode_req,
	input  wire logic                            wakeup,
	input  wire logic                            rtc_irq,
	input  wire logic                            vcore_wr,
	input  wire logic [1:0]                      vcore_sel,
	input  wire logic [N_PERIPH-1:0]             periph_en,
	output logic [pmc_pkg::PLL_CONTROL_REG_W-1:0]        pll_control_reg,
	output logic [2:0]                           mode,
	output logic                                 pll_enable,
	output logic                                 pll_bypass,
	output logic [pmc_pkg::PLL_CONTROL_REG_MSEL_W-1:0]   msel_applied,
	output logic                                 core_power_on,
	output logic                                 dma_l1_allow,
	output logic                                 hw_reset_req,
	output logic                                 cpu_domain_clk,
	output logic                                 sys_clk,
	output logic [N_PERIPH-1:0]                  periph_clk
);
	import pmc_pkg::*;

	// refuse gate counts the enable vector cannot serve
	if (N_PERIPH < 1 || N_PERIPH > 32)
	begin : g_bad_periph
		$error("N_PERIPH out of range");
	end

	pmc_mode_t                   mode_r, mode_nxt;
	logic [PLL_CONTROL_REG_W-1:0]        ctl_r, ctl_nxt;
	logic [PLL_CONTROL_REG_MSEL_W-1:0]   msel_r, msel_nxt;
	logic                        pll_en_r, pll_en_nxt;
	logic                        byp_r, byp_nxt;
	logic                        cpu_domain_clk_en_r, cpu_domain_clk_en_nxt;
	logic                        sclk_en_r, sclk_en_nxt;
	logic                        pwr_r, pwr_nxt;
	logic                        dma_r, dma_nxt;
	logic                        hwrst_r, hwrst_nxt;
	logic [N_PERIPH-1:0]         pen_r, pen_nxt;
	logic                        src_clk;

	// decode of the operating setting table
	function automatic logic [4:0] mode_profile(input pmc_mode_t m, input logic pll_on);
		// order: pll_en, bypass, cpu_domain_clk, sclk, power
		case (m)
			PMC_FULL_ON:    mode_profile = 5'b1_0_1_1_1;
			PMC_ACTIVE:     mode_profile = {pll_on, 4'b1_1_1_1};
			PMC_SLEEP:      mode_profile = 5'b1_0_0_1_1;
			PMC_DEEP_SLEEP: mode_profile = 5'b0_0_0_0_1;
			PMC_HIBERNATE:  mode_profile = 5'b0_0_0_0_0;
			default:        mode_profile = 5'b1_0_1_1_1;
		endcase
	endfunction

	// mode sequencing and control register
	always_comb
	begin
		logic [4:0] prof;
		prof      = 5'h00;
		mode_nxt  = mode_r;
		ctl_nxt   = ctl_r;
		msel_nxt  = msel_r;
		hwrst_nxt = 1'b0;
		if (ctl_wr && mode_r != PMC_HIBERNATE)
		begin
			ctl_nxt = ctl_wdata;
			// pll off only honoured in active
			if (mode_r != PMC_ACTIVE)
				ctl_nxt[PLL_CONTROL_REG_OFF_BIT] = ctl_r[PLL_CONTROL_REG_OFF_BIT];
		end
		case (mode_r)
			PMC_FULL_ON:
			begin
				if (vcore_wr && vcore_sel == VCORE_OFF)
					mode_nxt = PMC_HIBERNATE;
				else if (mode_req == REQ_SLEEP)
					mode_nxt = PMC_SLEEP;
				else if (mode_req == REQ_DEEP_SLEEP)
					mode_nxt = PMC_DEEP_SLEEP;
				else if (ctl_wr && ctl_wdata[PLL_CONTROL_REG_BYP_BIT])
					mode_nxt = PMC_ACTIVE;
			end
			PMC_ACTIVE:
			begin
				// relies on software re-enabling pll first
				if (vcore_wr && vcore_sel == VCORE_OFF)
					mode_nxt = PMC_HIBERNATE;
				else if (mode_req == REQ_SLEEP)
					mode_nxt = PMC_SLEEP;
				else if (mode_req == REQ_DEEP_SLEEP)
					mode_nxt = PMC_DEEP_SLEEP;
				else if (mode_req == REQ_FULL_ON)
					mode_nxt = PMC_FULL_ON;
			end
			PMC_SLEEP:
			begin
				if (wakeup)
					mode_nxt = ctl_r[PLL_CONTROL_REG_BYP_BIT] ? PMC_ACTIVE : PMC_FULL_ON;
			end
			PMC_DEEP_SLEEP:
			begin
				if (rtc_irq)
					mode_nxt = PMC_ACTIVE;
			end
			PMC_HIBERNATE:
			begin
				if (wakeup || rtc_irq)
					hwrst_nxt = 1'b1;
			end
			default:
				mode_nxt = PMC_FULL_ON;
		endcase
		if (mode_nxt == PMC_FULL_ON && mode_r != PMC_FULL_ON)
			msel_nxt = ctl_nxt[PLL_CONTROL_REG_MSEL_LO +: PLL_CONTROL_REG_MSEL_W];
		prof = mode_profile(mode_nxt, ~ctl_nxt[PLL_CONTROL_REG_OFF_BIT]);
		pll_en_nxt  = prof[4];
		byp_nxt     = prof[3];
		cpu_domain_clk_en_nxt = prof[2];
		sclk_en_nxt = prof[1];
		pwr_nxt     = prof[0];
		// dma allowed in full-on and active
		dma_nxt = (mode_nxt == PMC_FULL_ON) || (mode_nxt == PMC_ACTIVE);
		pen_nxt = prof[1] ? periph_en : '0;
	end

	// reset exits deep sleep to full-on
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			mode_r    <= PMC_FULL_ON;
			ctl_r     <= PLL_CONTROL_REG_RESET;
			msel_r    <= PLL_CONTROL_REG_RESET[PLL_CONTROL_REG_MSEL_LO +: PLL_CONTROL_REG_MSEL_W];
			pll_en_r  <= 1'b1;
			byp_r     <= 1'b0;
			cpu_domain_clk_en_r <= 1'b1;
			sclk_en_r <= 1'b1;
			pwr_r     <= 1'b1;
			dma_r     <= 1'b1;
			hwrst_r   <= 1'b0;
			pen_r     <= '0;
		end
		else if (clk_en)
		begin
			mode_r    <= mode_nxt;
			ctl_r     <= ctl_nxt;
			msel_r    <= msel_nxt;
			pll_en_r  <= pll_en_nxt;
			byp_r     <= byp_nxt;
			cpu_domain_clk_en_r <= cpu_domain_clk_en_nxt;
			sclk_en_r <= sclk_en_nxt;
			pwr_r     <= pwr_nxt;
			dma_r     <= dma_nxt;
			hwrst_r   <= hwrst_nxt;
			pen_r     <= pen_nxt;
		end
	end

	// registered status outputs
	assign pll_control_reg = ctl_r;
	assign mode            = mode_r;
	assign pll_enable      = pll_en_r;
	assign pll_bypass      = byp_r;
	assign msel_applied    = msel_r;
	assign core_power_on   = pwr_r;
	assign dma_l1_allow    = dma_r;
	assign hw_reset_req    = hwrst_r;

	assign src_clk = byp_r ? input_ref_clock : pll_clk;

	// glitch-free gates for core and system
	pmc_clk_gate u_cpu_domain_clk_gate
	(
		.clk_in  (src_clk),
		.enable  (cpu_domain_clk_en_r),
		.reset   (reset),
		.clk_out (cpu_domain_clk)
	);

	pmc_clk_gate u_sclk_gate
	(
		.clk_in  (src_clk),
		.enable  (sclk_en_r),
		.reset   (reset),
		.clk_out (sys_clk)
	);

	genvar gi;
	generate
		for (gi = 0; gi < N_PERIPH; gi++)
		begin : g_periph
			pmc_clk_gate u_pgate
			(
				.clk_in  (src_clk),
				.enable  (pen_r[gi]),
				.reset   (reset),
				.clk_out (periph_clk[gi])
			);
		end
	endgenerate
endmodule

// *** verif/pmc_ctl_assertions.sv ***
`timescale 1ns/10ps
module pmc_ctl_assertions
(
	input wire logic                          clk,
	input wire logic                          reset,
	input wire logic                          clk_en,
	input wire logic                          wakeup,
	input wire logic                          rtc_irq,
	input wire logic [2:0]                    mode,
	input wire logic [pmc_pkg::PLL_CONTROL_REG_W-1:0] pll_control_reg,
	input wire logic                          pll_enable,
	input wire logic                          pll_bypass,
	input wire logic                          core_power_on,
	input wire logic                          dma_l1_allow,
	input wire logic                          hw_reset_req,
	input wire logic                          cpu_domain_clk,
	input wire logic                          sys_clk,
	input wire logic [pmc_pkg::PLL_CONTROL_REG_MSEL_W-1:0] msel_applied
);
	import pmc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// settled low-power stays, long enough for gates
	sequence s_sleep3;
		mode == 3'h2 [*3];
	endsequence
	sequence s_deep3;
		mode == 3'h3 [*3];
	endsequence
	// per-mode levels
	a_full_on_pll: assert property
		(mode == 3'h0 |-> pll_enable && !pll_bypass && core_power_on) else $error("full-on levels");
	a_active_bypass: assert property
		(mode == 3'h1 |-> pll_bypass && dma_l1_allow && core_power_on) else $error("active levels");
	a_sleep_gate: assert property
		(s_sleep3 |-> !cpu_domain_clk && pll_enable && !dma_l1_allow) else $error("sleep levels");
	a_deep_gate: assert property
		(s_deep3 |-> !cpu_domain_clk && !sys_clk && !pll_enable && core_power_on) else $error("deep");
	a_hib_off: assert property
		(mode == 3'h4 |-> !pll_enable && !core_power_on) else $error("hibernate levels");
	// transitions
	a_sleep_wake: assert property
		(mode == 3'h2 && wakeup && clk_en |=>
		mode == ($past(pll_control_reg[PLL_CONTROL_REG_BYP_BIT]) ? 3'h1 : 3'h0)) else $error("sleep wake");
	a_deep_rtc: assert property
		(mode == 3'h3 && rtc_irq && clk_en |=> mode == 3'h1) else $error("deep rtc exit");
	a_hib_wake: assert property
		(mode == 3'h4 && (wakeup || rtc_irq) && clk_en |=> hw_reset_req) else $error("hib wake");
	a_active_msel: assert property
		($changed(msel_applied) |-> mode == 3'h0 && $past(mode) != 3'h0) else $error("msel");
	a_reset_full: assert property
		(disable iff (1'b0) reset |=> mode == 3'h0) else $error("reset mode");
endmodule

bind pmc_controller pmc_ctl_assertions u_chk
(
	.clk(clk), .reset(reset), .clk_en(clk_en), .wakeup(wakeup), .rtc_irq(rtc_irq), .mode(mode),
	.pll_control_reg(pll_control_reg), .pll_enable(pll_enable), .pll_bypass(pll_bypass),
	.core_power_on(core_power_on), .dma_l1_allow(dma_l1_allow), .hw_reset_req(hw_reset_req),
	.cpu_domain_clk(cpu_domain_clk), .sys_clk(sys_clk), .msel_applied(msel_applied)
);

// *** verif/test_power_mode_controller.sv ***
`timescale 1ns/10ps
module test_power_mode_controller;
	import pmc_pkg::*;
	logic        clk, reset, clk_en, pll_clk, input_ref_clock, ctl_wr, wakeup, rtc_irq, vcore_wr;
	logic        pll_enable, pll_bypass, core_power_on, dma_l1_allow, hw_reset_req;
	logic        cpu_domain_clk, sys_clk;
	logic [15:0] ctl_wdata, pll_control_reg;
	logic [1:0]  mode_req, vcore_sel;
	logic [7:0]  periph_en, periph_clk;
	logic [5:0]  msel_applied;
	logic [2:0]  mode;
	int          err_count = 0;
	int          total_checks = 0;

	pmc_controller u_dut
	(
		.clk(clk), .reset(reset), .clk_en(clk_en), .pll_clk(pll_clk),
		.input_ref_clock(input_ref_clock), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
		.mode_req(mode_req), .wakeup(wakeup), .rtc_irq(rtc_irq), .vcore_wr(vcore_wr),
		.vcore_sel(vcore_sel), .periph_en(periph_en), .pll_control_reg(pll_control_reg),
		.mode(mode), .pll_enable(pll_enable), .pll_bypass(pll_bypass),
		.msel_applied(msel_applied), .core_power_on(core_power_on),
		.dma_l1_allow(dma_l1_allow), .hw_reset_req(hw_reset_req),
		.cpu_domain_clk(cpu_domain_clk), .sys_clk(sys_clk), .periph_clk(periph_clk)
	);

	// controller clock and the two gated sources
	initial
	begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	always #7 pll_clk = ~pll_clk;
	always #11 input_ref_clock = ~input_ref_clock;

	// compare and count
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// one-cycle request: 0 mode, 1 ctl write, 2 wakeup, 3 rtc, else supply
	task pulse(input int s, input logic [15:0] d);
		@(posedge clk);
		case (s)
			0: mode_req <= d[1:0];
			1: ctl_wr <= 1'h1;
			2: wakeup <= 1'h1;
			3: rtc_irq <= 1'h1;
			default: vcore_wr <= 1'h1;
		endcase
		ctl_wdata <= d;
		vcore_sel <= d[1:0];
		@(posedge clk);
		{mode_req, ctl_wr, wakeup, rtc_irq, vcore_wr} <= 6'h00;
		#1;
	endtask

	task t_reset;
		#1;
		chk("mode", 16'h0000, mode);
		chk("ctl", 16'h0a00, pll_control_reg);
		chk("msel", 16'h0005, msel_applied);
		chk("pll", 16'h0002, {pll_enable, pll_bypass});
		@(posedge clk);
		repeat (3) @(posedge pll_clk);
		#1;
		chk("periph", 16'h000f, periph_clk);
		chk("clocks", 16'h0003, {cpu_domain_clk, sys_clk});
		$display("t_reset done");
	endtask

	task t_sleep;
		@(posedge clk);
		clk_en <= 1'h0;
		pulse(0, 16'h0002);
		chk("frozen", 16'h0000, mode);
		@(posedge clk);
		clk_en <= 1'h1;
		pulse(0, 16'h0002);
		repeat (3) @(posedge clk);
		#1;
		chk("sleep", 16'h0002, mode);
		chk("sleep clks", 16'h0001, {cpu_domain_clk, pll_enable});
		chk("dma", 16'h0000, dma_l1_allow);
		pulse(2, 16'h0000);
		chk("wake", 16'h0000, mode);
		pulse(1, 16'h0b00);
		chk("active", 16'h0007, {mode[0], pll_bypass, dma_l1_allow});
		pulse(0, 16'h0002);
		repeat (3) @(posedge clk);
		pulse(2, 16'h0000);
		chk("wake byp", 16'h0001, mode);
		$display("t_sleep done");
	endtask

	task t_active;
		pulse(1, 16'h1902);
		chk("pll off", 16'h0000, pll_enable);
		chk("msel held", 16'h0005, msel_applied);
		pulse(1, 16'h1900);
		pulse(0, 16'h0001);
		chk("full", 16'h000c, {mode, msel_applied});
		$display("t_active done");
	endtask

	task t_deep;
		pulse(0, 16'h0003);
		repeat (3) @(posedge clk);
		#1;
		chk("deep", 16'h0006, {mode, pll_enable});
		chk("deep clks", 16'h0000, {cpu_domain_clk, sys_clk, periph_clk});
		pulse(3, 16'h0000);
		chk("rtc", 16'h0001, mode);
		pulse(0, 16'h0001);
		pulse(0, 16'h0003);
		@(posedge clk);
		reset <= 1'h1;
		@(posedge clk);
		reset <= 1'h0;
		#1;
		chk("deep rst", 16'h0001, {mode, pll_enable});
		$display("t_deep done");
	endtask

	task t_hib;
		pulse(4, 16'h0000);
		chk("hib", 16'h0008, {mode, core_power_on});
		pulse(2, 16'h0000);
		chk("hw reset", 16'h0001, hw_reset_req);
		@(posedge clk);
		reset <= 1'h1;
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		#1;
		chk("rst mode", 16'h0000, mode);
		$display("t_hib done");
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// main sequence
	initial
	begin
		{reset, clk_en, pll_clk, input_ref_clock} = 4'h0;
		reset = 1'h1;
		clk_en = 1'h1;
		{ctl_wr, wakeup, rtc_irq, vcore_wr} = 4'h0;
		ctl_wdata = 16'h0000;
		mode_req = 2'h0;
		vcore_sel = 2'h3;
		periph_en = 8'h0f;
		repeat (4) @(posedge clk);
		reset <= 1'h0;
		t_reset;
		t_sleep;
		t_active;
		t_deep;
		t_hib;
		conclude;
	end

	// watchdog
	initial
	begin
		#100000;
		err_count++;
		conclude;
	end
endmodule
